// File: rtl/clk_seq_pkg.sv
// Shared constants and carriers for the safe clock startup sequencer.
// Assumes all clock activity is presented as one-cycle ticks on ref_clk.
package clk_seq_pkg;

  localparam int          CLK_PERIOD_NS  = 20;
  localparam int          MAX_IN_CLOCKS  = 2;
  localparam int          MAX_OUT_CLOCKS = 7;
  localparam int          SEQ_W          = 3;
  localparam logic [3:0]  LOCK_CYCLES    = 4'h8;
  localparam logic [3:0]  SEQ_GAP_CYCLES = 4'h8;
  localparam logic [1:0]  FB_INTERNAL    = 2'h0;
  localparam logic [1:0]  FB_AUTO_MATCH  = 2'h1;
  localparam logic [1:0]  FB_USER        = 2'h2;
  localparam logic        PWRDWN_TIE     = 1'h0;

  typedef enum logic [1:0] {
    ST_QUALIFY = 2'b00,
    ST_RELEASE = 2'b01,
    ST_GAP     = 2'b10,
    ST_DONE    = 2'b11
  } seq_state_t;

  typedef struct packed {
    logic       lock_ok;
    logic       all_on;
    logic [2:0] step;
  } seq_status_t;

endpackage

// File: rtl/enable_gated_global_buffer.sv
// Enable-capable output clock buffer cell.
// Assumes the clock it passes is a tick synchronous to ref_clk.
`timescale 1ns/1ps
`default_nettype none

module enable_gated_global_buffer (
  input  wire logic ref_clk,
  input  wire logic rst,
  input  wire logic enable,
  input  wire logic clk_tick,
  output var  logic gated_tick
);

  logic gated_reg;
  logic gated_next;

  always_comb begin
    gated_next = enable & clk_tick;
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      gated_reg <= 1'h0;
    end else begin
      gated_reg <= gated_next;
    end
  end

  assign gated_tick = gated_reg;

endmodule // enable_gated_global_buffer

`default_nettype wire

// File: rtl/safe_clock_startup_sequencer.sv
// Safe clock startup and sequencing wrapper around a clock synthesis
// primitive (mixed_mode_clock_manager).
// Assumes the primitive's clocks, lock flag and feedback are synchronous
// ticks and levels on ref_clk.
`timescale 1ns/1ps
`default_nettype none

module safe_clock_startup_sequencer #(
  parameter int                 N_USED     = 7,
  parameter bit                 SEQ_EN     = 1'b1,
  parameter logic [20:0]        SEQ_NUMS   = 21'h1F58D1,
  parameter logic [1:0]         FB_MODE    = clk_seq_pkg::FB_INTERNAL,
  parameter bit                 IN1_BUF    = 1'b1,
  parameter bit                 IN2_BUF    = 1'b1,
  parameter bit                 IN2_USED   = 1'b0
) (
  input  wire logic                   ref_clk,
  input  wire logic                   rst,
  input  wire logic                   in_clk1_tick,
  input  wire logic                   in_clk2_tick,
  input  wire logic                   in_clk_sel,
  input  wire logic                   prim_locked,
  input  wire logic [6:0]             prim_out_tick,
  input  wire logic                   prim_fb_out,
  input  wire logic                   fb_ext_in,
  output var  logic                   prim_clk_in1,
  output var  logic                   prim_clk_in2,
  output var  logic                   prim_fb_in,
  output var  logic                   prim_pwrdwn,
  output var  logic                   fb_ext_out,
  output var  logic [6:0]             out_clk_tick,
  output var  logic [6:0]             out_enabled,
  output var  clk_seq_pkg::seq_status_t status
);

  ////////////////////////////////////////////////////////////////////////////
  // Input clock buffering and selection.

  logic in1_stage_reg;
  logic in2_stage_reg;
  logic in1_reg;
  logic in2_reg;
  logic in1_next;
  logic in2_next;
  logic pwrdwn_reg;
  logic in_tick;

  always_comb begin
    in1_next = IN1_BUF ? in1_stage_reg : in_clk1_tick;
    in2_next = IN2_BUF ? in2_stage_reg : in_clk2_tick;
    if (!IN2_USED) begin
      in2_next = 1'h0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      in1_stage_reg <= 1'h0;
      in2_stage_reg <= 1'h0;
      in1_reg       <= 1'h0;
      in2_reg       <= 1'h0;
      pwrdwn_reg    <= 1'h0;
    end else begin
      in1_stage_reg <= in_clk1_tick;
      in2_stage_reg <= in_clk2_tick;
      in1_reg       <= in1_next;
      in2_reg       <= in2_next;
      pwrdwn_reg    <= clk_seq_pkg::PWRDWN_TIE;
    end
  end

  // Lock is qualified against the input clock the primitive is using.
  assign in_tick      = (IN2_USED && in_clk_sel) ? in2_reg : in1_reg;
  assign prim_clk_in1 = in1_reg;
  assign prim_clk_in2 = in2_reg;
  assign prim_pwrdwn  = pwrdwn_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Startup sequencer.

  // Returns the output index that carries sequence number seq.
  function automatic logic [2:0] find_out(input logic [2:0] seq);
    logic [2:0] idx;
    idx = 3'h0;
    for (int i = 0; i < clk_seq_pkg::MAX_OUT_CLOCKS; i++) begin
      if (i < N_USED && SEQ_NUMS[i*3 +: 3] == seq) begin
        idx = 3'(i);
      end
    end
    return idx;
  endfunction

  localparam logic [6:0] USED_MASK = 7'((8'h1 << N_USED) - 8'h1);

  clk_seq_pkg::seq_state_t state_reg;
  clk_seq_pkg::seq_state_t state_next;
  logic [3:0] cnt_reg;
  logic [3:0] cnt_next;
  logic [2:0] step_reg;
  logic [2:0] step_next;
  logic [6:0] mask_reg;
  logic [6:0] mask_next;
  logic       lock_ok_reg;
  logic       lock_ok_next;
  logic [2:0] cur_out;
  logic       all_on_reg;
  logic       all_on_next;

  always_comb begin
    state_next   = state_reg;
    cnt_next     = cnt_reg;
    step_next    = step_reg;
    mask_next    = mask_reg;
    lock_ok_next = lock_ok_reg;
    cur_out      = find_out(step_reg);
    if (!prim_locked) begin
      state_next   = clk_seq_pkg::ST_QUALIFY;
      cnt_next     = 4'h0;
      step_next    = 3'h1;
      mask_next    = 7'h00;
      lock_ok_next = 1'h0;
    end else begin
      case (state_reg)
        clk_seq_pkg::ST_QUALIFY: begin
          if (in_tick) begin
            cnt_next = cnt_reg + 4'h1;
            if (cnt_reg + 4'h1 == clk_seq_pkg::LOCK_CYCLES) begin
              state_next   = clk_seq_pkg::ST_RELEASE;
              lock_ok_next = 1'h1;
              cnt_next     = 4'h0;
            end
          end
        end
        clk_seq_pkg::ST_RELEASE: begin
          if (!SEQ_EN) begin
            mask_next  = USED_MASK;
            state_next = clk_seq_pkg::ST_DONE;
          end else begin
            mask_next[cur_out] = 1'h1;
            if (step_reg == 3'(N_USED)) begin
              state_next = clk_seq_pkg::ST_DONE;
            end else begin
              step_next  = step_reg + 3'h1;
              cnt_next   = 4'h0;
              state_next = clk_seq_pkg::ST_GAP;
            end
          end
        end
        clk_seq_pkg::ST_GAP: begin
          // The gap is counted on the ungated clock of the next output.
          if (prim_out_tick[cur_out]) begin
            cnt_next = cnt_reg + 4'h1;
            if (cnt_reg + 4'h1 == clk_seq_pkg::SEQ_GAP_CYCLES) begin
              state_next = clk_seq_pkg::ST_RELEASE;
              cnt_next   = 4'h0;
            end
          end
        end
        clk_seq_pkg::ST_DONE: begin
          state_next = clk_seq_pkg::ST_DONE;
        end
        default: begin
          state_next = clk_seq_pkg::ST_QUALIFY;
        end
      endcase
    end
    all_on_next = (state_next == clk_seq_pkg::ST_DONE);
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      all_on_reg  <= 1'h0;
      state_reg   <= clk_seq_pkg::ST_QUALIFY;
      cnt_reg     <= 4'h0;
      step_reg    <= 3'h1;
      mask_reg    <= 7'h00;
      lock_ok_reg <= 1'h0;
    end else begin
      all_on_reg  <= all_on_next;
      state_reg   <= state_next;
      cnt_reg     <= cnt_next;
      step_reg    <= step_next;
      mask_reg    <= mask_next;
      lock_ok_reg <= lock_ok_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Output clock buffers.

  logic [6:0] gated;

  for (genvar g = 0; g < clk_seq_pkg::MAX_OUT_CLOCKS; g++) begin : g_out
    enable_gated_global_buffer u_buf (
      .ref_clk    (ref_clk),
      .rst        (rst),
      .enable     (mask_reg[g] & USED_MASK[g]),
      .clk_tick   (prim_out_tick[g]),
      .gated_tick (gated[g])
    );
  end

  assign out_clk_tick = gated;
  assign out_enabled  = mask_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Feedback routing.

  logic fb_matched;
  logic fb_reg;
  logic fb_next;
  logic fb_ext_reg;
  logic fb_ext_next;

  // The matching cell has the same latency as the first output clock path.
  enable_gated_global_buffer u_fb_match (
    .ref_clk    (ref_clk),
    .rst        (rst),
    .enable     (1'h1),
    .clk_tick   (prim_fb_out),
    .gated_tick (fb_matched)
  );

  always_comb begin
    case (FB_MODE)
      clk_seq_pkg::FB_AUTO_MATCH: begin
        fb_next     = fb_matched;
        fb_ext_next = 1'h0;
      end
      clk_seq_pkg::FB_USER: begin
        fb_next     = fb_ext_in;
        fb_ext_next = prim_fb_out;
      end
      default: begin
        fb_next     = prim_fb_out;
        fb_ext_next = 1'h0;
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      fb_reg     <= 1'h0;
      fb_ext_reg <= 1'h0;
    end else begin
      fb_reg     <= fb_next;
      fb_ext_reg <= fb_ext_next;
    end
  end

  assign prim_fb_in = fb_reg;
  assign fb_ext_out = fb_ext_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Status.

  always_comb begin
    status.lock_ok = lock_ok_reg;
    status.all_on  = all_on_reg;
    status.step    = step_reg;
  end

endmodule // safe_clock_startup_sequencer

`default_nettype wire

// File: sim/seq_chk.sv
// Port checker for the startup sequencer; feedback checks follow FB_MODE.
// Assumes seven outputs released in ascending order.
`timescale 1ns/1ps
`default_nettype none
module seq_chk #(
  parameter logic [1:0] FB_MODE = clk_seq_pkg::FB_INTERNAL
) (
  input wire logic                     ref_clk,
  input wire logic                     rst,
  input wire logic                     in_clk1_tick,
  input wire logic                     fb_ext_in,
  input wire logic                     prim_locked,
  input wire logic [6:0]               prim_out_tick,
  input wire logic                     prim_fb_out,
  input wire logic                     prim_clk_in1,
  input wire logic                     prim_clk_in2,
  input wire logic                     prim_fb_in,
  input wire logic                     prim_pwrdwn,
  input wire logic                     fb_ext_out,
  input wire logic [6:0]               out_clk_tick,
  input wire logic [6:0]               out_enabled,
  input wire clk_seq_pkg::seq_status_t status
);
  logic [3:0] run_reg, run_next, gap_reg, gap_next;
  logic [6:0] en_reg;
  logic [7:0] tk;
  assign tk = {1'b0, prim_out_tick};
  always_comb begin
    // Qualifying input ticks seen while lock stays high.
    run_next = 4'h0;
    if (prim_locked) begin
      run_next = run_reg + {3'h0, prim_clk_in1 && run_reg != 4'hF};
    end
    gap_next = gap_reg + {3'h0, tk[$countones(out_enabled)]};
    if (out_enabled != en_reg) gap_next = {3'h0, tk[$countones(out_enabled)]};
  end
  always_ff @(posedge ref_clk) begin
    run_reg <= rst ? 4'h0 : run_next;
    gap_reg <= rst ? 4'h0 : gap_next;
    en_reg  <= rst ? 7'h00 : out_enabled;
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  sequence first_on_s; $rose(|out_enabled); endsequence
  sequence next_on_s;
    $changed(out_enabled) && |$past(out_enabled) && |out_enabled;
  endsequence
  lock_qualify_a: assert property (
    $rose(status.lock_ok) |-> run_reg == 4'h8)
    else $error("lock_ok rose after a wrong tick count");
  gate_before_a: assert property (first_on_s |-> status.lock_ok && out_enabled == 7'h01)
    else $error("output enabled before lock");
  seq_order_a: assert property (next_on_s |-> out_enabled == {$past(out_enabled[5:0]), 1'b1})
    else $error("output order wrong");
  seq_gap_a: assert property (next_on_s |-> $past(gap_reg) == 4'h8)
    else $error("gap between releases wrong");
  all_on_a: assert property (status.all_on |-> out_enabled == 7'h7F)
    else $error("all_on without full mask");
  fb_loop_a: assert property (
    prim_fb_in == (FB_MODE == clk_seq_pkg::FB_USER ? $past(fb_ext_in)
      : FB_MODE == clk_seq_pkg::FB_AUTO_MATCH ? $past(prim_fb_out, 2)
      : $past(prim_fb_out)))
    else $error("feedback loop wrong");
  fb_expose_a: assert property (
    fb_ext_out == (FB_MODE == clk_seq_pkg::FB_USER ? $past(prim_fb_out)
      : 1'b0))
    else $error("exposed feedback wrong");
  in_buffer_a: assert property (prim_clk_in1 == $past(in_clk1_tick, 2))
    else $error("input clock path wrong");
  tie_off_a: assert property (!prim_pwrdwn && !prim_clk_in2)
    else $error("tie-off wrong");
  gated_tick_a: assert property (out_clk_tick == ($past(out_enabled) & $past(prim_out_tick)))
    else $error("gated tick wrong");
  lock_loss_a: assert property (!prim_locked |=> out_enabled == 7'h00)
    else $error("outputs kept after lock loss");
endmodule // seq_chk
bind safe_clock_startup_sequencer seq_chk #(.FB_MODE(FB_MODE)) i_chk (
  .ref_clk(ref_clk), .rst(rst), .in_clk1_tick(in_clk1_tick),
  .fb_ext_in(fb_ext_in),
  .prim_locked(prim_locked), .prim_out_tick(prim_out_tick),
  .prim_fb_out(prim_fb_out), .prim_clk_in1(prim_clk_in1),
  .prim_clk_in2(prim_clk_in2), .prim_fb_in(prim_fb_in),
  .prim_pwrdwn(prim_pwrdwn), .fb_ext_out(fb_ext_out),
  .out_clk_tick(out_clk_tick), .out_enabled(out_enabled), .status(status));
`default_nettype wire

// File: sim/prim_model.sv
// Behavioural clock synthesis primitive.
// Assumes lock_req and slow come from the bench.
`timescale 1ns/1ps
`default_nettype none
module prim_model (
  input  wire logic       ref_clk,
  input  wire logic       rst,
  input  wire logic       lock_req,
  input  wire logic       slow,
  output var  logic       prim_locked,
  output var  logic [6:0] prim_out_tick,
  output var  logic       prim_fb_out
);
  // Outputs tick at like rates, so neighbours stay within a factor of eight.
  always @(posedge ref_clk) begin
    prim_locked   <= !rst && lock_req;
    prim_out_tick <= rst ? 7'h00 : 7'($urandom) & (slow ? 7'($urandom) : 7'h7F);
    prim_fb_out   <= !rst && 1'($urandom);
  end
endmodule // prim_model
`default_nettype wire

// File: sim/testbench.sv
// Self-checking bench for the startup sequencer.
// Assumes the prim_model partner; two extra instances cover feedback modes.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic ref_clk = 1'b0, rst = 1'b1, lock_req = 1'b0, slow = 1'b0;
  logic tick_on = 1'b0, in1 = 1'b0, in2 = 1'b0, sel = 1'b0, fbx = 1'b0;
  logic locked, fb_out, pci1, pci2, pfb, ppd, fbo;
  logic fbo_u, pfb_u, pfb_a, fb_prev = 1'b0, fb_prev2 = 1'b0, fbx_prev = 1'b0;
  logic [1:0] in1_d = 2'h0;
  logic [6:0] ptick, otick, oen;
  clk_seq_pkg::seq_status_t st;
  int n_mismatch = 0, checks_done = 0, cyc = 0, ticks = 0;
  always #10 ref_clk = ~ref_clk;
  prim_model i_prim (.ref_clk(ref_clk), .rst(rst), .lock_req(lock_req),
    .slow(slow), .prim_locked(locked), .prim_out_tick(ptick),
    .prim_fb_out(fb_out));
  safe_clock_startup_sequencer i_dut (.ref_clk(ref_clk), .rst(rst),
    .in_clk1_tick(in1), .in_clk2_tick(in2), .in_clk_sel(sel),
    .prim_locked(locked), .prim_out_tick(ptick), .prim_fb_out(fb_out),
    .fb_ext_in(fbx), .prim_clk_in1(pci1), .prim_clk_in2(pci2),
    .prim_fb_in(pfb), .prim_pwrdwn(ppd), .fb_ext_out(fbo),
    .out_clk_tick(otick), .out_enabled(oen), .status(st));
  safe_clock_startup_sequencer #(.FB_MODE(clk_seq_pkg::FB_USER)) i_dut_user (
    .ref_clk(ref_clk), .rst(rst), .in_clk1_tick(in1), .in_clk2_tick(in2),
    .in_clk_sel(sel), .prim_locked(locked), .prim_out_tick(ptick),
    .prim_fb_out(fb_out), .fb_ext_in(fbx), .prim_clk_in1(),
    .prim_clk_in2(), .prim_fb_in(pfb_u), .prim_pwrdwn(),
    .fb_ext_out(fbo_u), .out_clk_tick(), .out_enabled(), .status());
  safe_clock_startup_sequencer #(.FB_MODE(clk_seq_pkg::FB_AUTO_MATCH))
    i_dut_auto (
    .ref_clk(ref_clk), .rst(rst), .in_clk1_tick(in1), .in_clk2_tick(in2),
    .in_clk_sel(sel), .prim_locked(locked), .prim_out_tick(ptick),
    .prim_fb_out(fb_out), .fb_ext_in(fbx), .prim_clk_in1(),
    .prim_clk_in2(), .prim_fb_in(pfb_a), .prim_pwrdwn(),
    .fb_ext_out(), .out_clk_tick(), .out_enabled(), .status());
  always @(posedge ref_clk) begin
    in1 <= tick_on && 1'($urandom);
    in2 <= 1'($urandom);
    sel <= 1'($urandom);
    fbx <= !rst && 1'($urandom);
    // Lock ticks as the design sees them, behind two input buffer flops.
    in1_d <= {in1_d[0], in1};
    ticks <= locked ? ticks + int'(in1_d[1]) : 0;
    fb_prev <= fb_out;
    fb_prev2 <= fb_prev;
    fbx_prev <= fbx;
    if (!rst && cyc > 8) begin
      cmp({6'h0, fbo_u, pfb_u}, {6'h0, fb_prev, fbx_prev});
      cmp({7'h0, pfb_a}, {7'h0, fb_prev2});
    end
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_mismatch++;
      test_done();
    end
  end
  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic run(input int n);
    int k = 0, t = 0, g = 0, gq = 0;
    logic [6:0] prev = 7'h00;
    logic lk = 1'b0;
    @(posedge ref_clk);
    lock_req <= 1'b1;
    while (k < n && t < 3000) begin
      @(posedge ref_clk);
      #1;
      t++;
      if (st.lock_ok === 1'b1 && lk === 1'b0) cmp(8'(ticks), 8'h08);
      if (st.lock_ok !== 1'b1) cmp({1'b0, oen}, 8'h00);
      lk = st.lock_ok;
      if (oen !== prev) begin
        k++;
        cmp({1'b0, oen}, 8'((1 << k) - 1));
        if (k > 1) cmp(8'(gq), 8'h08);
        g = 0;
      end
      prev = oen;
      gq = g;
      if (k < 7) g += int'(ptick[k]);
    end
    cmp(8'(k), 8'(n));
    $display("test startup of %0d outputs done", n);
  endtask
  task automatic drop();
    @(posedge ref_clk);
    lock_req <= 1'b0;
    repeat (3) @(posedge ref_clk);
    #1;
    cmp({st.lock_ok, oen}, 8'h00);
    @(posedge ref_clk);
    lock_req <= 1'b1;
    repeat (6) @(posedge ref_clk);
    lock_req <= 1'b0;
    repeat (6) begin
      @(posedge ref_clk);
      #1;
      cmp({st.lock_ok, oen}, 8'h00);
    end
    $display("test lock loss done");
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    void'($urandom(29975));
    repeat (4) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    tick_on <= 1'b1;
    run(3);
    drop();
    slow <= 1'b1;
    run(7);
    repeat (2) @(posedge ref_clk);
    #1;
    cmp({7'h0, st.all_on}, 8'h01);
    drop();
    test_done();
  end
endmodule // testbench
`default_nettype wire
